// *** wiper_pkg.sv ***
/*
 Shared constants and types for the push-button wiper control.
 Assumes a 100 MHz system clock; only the tick period is converted to a cycle count here, other times stay in milliseconds.
*/
package wiper_pkg;
    // ----------------------------------------------------------------
    // Geometry
    // ----------------------------------------------------------------
    localparam int unsigned POS_W      = 5;
    localparam int unsigned TAP_N      = 32;
    localparam logic [4:0]  POS_RESET  = 5'h00;
    localparam logic [4:0]  POS_MAX    = 5'h1f;
    localparam logic [4:0]  POS_MIN    = 5'h00;

    // ----------------------------------------------------------------
    // Timing
    // ----------------------------------------------------------------
    localparam int unsigned CLK_HZ       = 100_000_000;
    localparam int unsigned TICK_US      = 1000;
    localparam int unsigned TICK_CYC     = (CLK_HZ / 1_000_000) * TICK_US;
    localparam int unsigned DEBOUNCE_MS  = 15;
    localparam int unsigned SLOW_STEP_MS = 250;
    localparam int unsigned FAST_STEP_MS = 50;
    localparam int unsigned FAST_AFTER_MS = 1000;
    localparam int unsigned SHUTDOWN_MS  = 2000;
    localparam int unsigned WAKE_SCAN_MS = 250;
    localparam int unsigned MS_W         = 12;

    // ----------------------------------------------------------------
    // Types
    // ----------------------------------------------------------------
    typedef enum logic [5:0] {
        ST_IDLE     = 6'b000001,
        ST_SCAN     = 6'b000010,
        ST_BOTH     = 6'b000100,
        ST_LOCKOUT  = 6'b001000,
        ST_SHUTDOWN = 6'b010000,
        ST_WAKE     = 6'b100000
    } ctl_state_t;

    typedef struct packed {
        logic up;
        logic down;
    } buttons_t;
endpackage

// *** button_debounce.sv ***
/*
 Synchroniser and debouncer for one active-low button.
 Assumes a one-cycle millisecond tick from the same clock.
*/
`timescale 1ns/1ps
module button_debounce #(
    parameter int unsigned DB_MS = 15
) (
    input  wire logic SYS_CLK_I,
    input  wire logic SYS_RST_I,
    input  wire logic ms_tick_i,
    input  wire logic button_n_i,
    output logic      pressed_o
);
    import wiper_pkg::*;

    if (DB_MS < 1 || DB_MS > 255) begin : g_db_range
        $error("DB_MS out of range");
    end

    // ----------------------------------------------------------------
    // Three-stage synchroniser; idle level high as the pull-up gives
    // ----------------------------------------------------------------
    logic [2:0] sync_q;
    logic [7:0] cnt_q;
    logic [7:0] cnt_d;
    logic       stable_low;
    logic       pressed_q;

    assign stable_low = ~sync_q[1] & ~sync_q[2];
    assign cnt_d      = !stable_low ? 8'h00 :
                        (ms_tick_i && cnt_q != 8'(DB_MS)) ? cnt_q + 8'h01 : cnt_q;

    always_ff @(posedge SYS_CLK_I or posedge SYS_RST_I) begin
        if (SYS_RST_I) begin
            sync_q    <= 3'h7;
            cnt_q     <= 8'h00;
            pressed_q <= 1'b0;
        end else begin
            sync_q    <= {sync_q[1:0], button_n_i};
            cnt_q     <= cnt_d;
            pressed_q <= stable_low && (cnt_q == 8'(DB_MS));
        end
    end

    assign pressed_o = pressed_q;

    AST_RELEASE_DROPS: assert property (@(posedge SYS_CLK_I) disable iff (SYS_RST_I)
        (sync_q[1] & sync_q[2]) |=> !pressed_o) else $error("press held after release");
endmodule // button_debounce

// *** ms_timebase.sv ***
/*
 Millisecond tick divider from the system clock.
 Assumes one free-running clock.
*/
`timescale 1ns/1ps
module ms_timebase #(
    parameter int unsigned DIV = 100000
) (
    input  wire logic SYS_CLK_I,
    input  wire logic SYS_RST_I,
    output logic      tick_o
);
    if (DIV < 2 || DIV > 1 << 20) begin : g_div_range
        $error("DIV out of range");
    end

    logic [19:0] cnt_q;
    logic        tick_q;
    logic        wrap;

    assign wrap = (cnt_q == 20'(DIV - 1));

    always_ff @(posedge SYS_CLK_I or posedge SYS_RST_I) begin
        if (SYS_RST_I) begin
            cnt_q  <= 20'h00000;
            tick_q <= 1'b0;
        end else begin
            cnt_q  <= wrap ? 20'h00000 : cnt_q + 20'h00001;
            tick_q <= wrap;
        end
    end

    assign tick_o = tick_q;
endmodule // ms_timebase

// *** push_button_wiper_control.sv ***
/*
 Top of the push-button wiper control: debounce, scan timing, shutdown,
 saturating 5-bit position counter and one-hot tap select.
 Assumes buttons are active low and driven high when released; clock is free running.
*/
`timescale 1ns/1ps

// What this block does
// - Reset puts the wiper at tap zero.
// - No internal pull-up: released buttons must be driven high.
// - Five-bit position; up increments, down decrements.
// - Position decoded one-hot to exactly one tap.
// - Debounced up press steps one tap toward high end.
// - Debounced down press steps one tap toward low end.
// - Presses shorter than the debounce interval do nothing.
// - Short press gives one step; holding repeats steps.
// - First second of hold repeats at slow rate.
// - After one second of hold, repeat at fast rate.
// - Release stops stepping and returns to idle.
// - Buttons pressed far apart: drop all until both released.
// - Position saturates at 0 and 31, never wraps.
// - Both held two seconds enters shutdown.
// - Shutdown cuts high end and selects tap zero.
// - Debounced press in shutdown exits and restores saved position.
// - Holding past 250 ms from the press (250 ms less DB_MS after exit) starts auto stepping.
// - Slow step interval 250 ms.
// - Fast step interval 50 ms.
module push_button_wiper_control #(
    parameter int unsigned TICK_DIV = wiper_pkg::TICK_CYC,
    parameter int unsigned DB_MS    = wiper_pkg::DEBOUNCE_MS
) (
    input  wire logic                         SYS_CLK_I,
    input  wire logic                         SYS_RST_I,
    input  wire logic                         STEP_UP_BUTTON_N_I,
    input  wire logic                         STEP_DOWN_BUTTON_N_I,
    output logic [wiper_pkg::TAP_N-1:0]       TAP_SELECT_O,
    output logic [wiper_pkg::POS_W-1:0]       WIPER_POS_O,
    output logic                              HIGH_END_DISCONNECT_O,
    output logic                              SHUTDOWN_O
);
    import wiper_pkg::*;

    if (DB_MS < 1 || DB_MS >= SLOW_STEP_MS) begin : g_db_check
        $error("DB_MS out of range");
    end

    // ----------------------------------------------------------------
    // Timebase and debouncers
    // ----------------------------------------------------------------
    logic     ms_tick;
    buttons_t pressed;

    ms_timebase #(.DIV(TICK_DIV)) u_tick (
        .SYS_CLK_I (SYS_CLK_I),
        .SYS_RST_I (SYS_RST_I),
        .tick_o    (ms_tick)
    );

    button_debounce #(.DB_MS(DB_MS)) u_db_up (
        .SYS_CLK_I  (SYS_CLK_I),
        .SYS_RST_I  (SYS_RST_I),
        .ms_tick_i  (ms_tick),
        .button_n_i (STEP_UP_BUTTON_N_I),
        .pressed_o  (pressed.up)
    );

    button_debounce #(.DB_MS(DB_MS)) u_db_down (
        .SYS_CLK_I  (SYS_CLK_I),
        .SYS_RST_I  (SYS_RST_I),
        .ms_tick_i  (ms_tick),
        .button_n_i (STEP_DOWN_BUTTON_N_I),
        .pressed_o  (pressed.down)
    );

    // ----------------------------------------------------------------
    // State and counters
    // ----------------------------------------------------------------
    ctl_state_t        state_q;
    ctl_state_t        state_d;
    logic [MS_W-1:0]   hold_ms_q;
    logic [MS_W-1:0]   hold_ms_d;
    logic [MS_W-1:0]   step_ms_q;
    logic [MS_W-1:0]   step_ms_d;
    logic [MS_W-1:0]   gap_ms_q;
    logic [MS_W-1:0]   gap_ms_d;
    logic              dir_up_q;
    logic              dir_up_d;
    logic [POS_W-1:0]  pos_q;
    logic [POS_W-1:0]  pos_d;
    logic [POS_W-1:0]  saved_q;
    logic [POS_W-1:0]  saved_d;
    logic              step_now;
    logic              restore_now;
    logic              save_now;

    wire any_pressed  = pressed.up | pressed.down;
    wire both_pressed = pressed.up & pressed.down;
    wire one_pressed  = any_pressed & ~both_pressed;
    wire hold_sat     = (hold_ms_q == 12'hfff);
    wire fast_mode    = (hold_ms_q >= 12'(FAST_AFTER_MS));
    wire [MS_W-1:0] step_int = fast_mode ? 12'(FAST_STEP_MS) : 12'(SLOW_STEP_MS);
    wire step_due     = ms_tick && (step_ms_q + 12'h001 >= step_int);
    wire at_top       = (pos_q == POS_MAX);
    wire at_bot       = (pos_q == POS_MIN);

    // ----------------------------------------------------------------
    // Control sequencing
    // ----------------------------------------------------------------
    always_comb begin
        state_d     = state_q;
        hold_ms_d   = (ms_tick && !hold_sat) ? hold_ms_q + 12'h001 : hold_ms_q;
        step_ms_d   = ms_tick ? step_ms_q + 12'h001 : step_ms_q;
        gap_ms_d    = gap_ms_q;
        dir_up_d    = dir_up_q;
        step_now    = 1'b0;
        restore_now = 1'b0;
        save_now    = 1'b0;
        case (state_q)
            ST_IDLE: begin
                hold_ms_d = 12'h000;
                step_ms_d = 12'h000;
                gap_ms_d  = 12'h000;
                if (both_pressed) begin
                    state_d = ST_BOTH;
                end else if (one_pressed) begin
                    // Debounced press steps once at once
                    state_d  = ST_SCAN;
                    dir_up_d = pressed.up;
                    step_now = 1'b1;
                end
            end
            ST_SCAN: begin
                if (!any_pressed) begin
                    state_d = ST_IDLE;
                end else if (both_pressed && hold_ms_q < 12'(DB_MS)) begin
                    // Second press inside the window: undo the first step, keep counting
                    state_d     = ST_BOTH;
                    restore_now = 1'b1;
                end else if (both_pressed) begin
                    // Second press came a debounce interval late
                    state_d = ST_LOCKOUT;
                end else if (step_due) begin
                    step_ms_d = 12'h000;
                    step_now  = 1'b1;
                end
            end
            ST_BOTH: begin
                if (!both_pressed) begin
                    state_d = ST_LOCKOUT;
                end else if (hold_ms_q >= 12'(SHUTDOWN_MS)) begin
                    state_d  = ST_SHUTDOWN;
                    save_now = 1'b1;
                end
            end
            ST_LOCKOUT: begin
                // Nothing acts until every button is up
                if (!any_pressed) begin
                    state_d = ST_IDLE;
                end
            end
            ST_SHUTDOWN: begin
                hold_ms_d = 12'h000;
                step_ms_d = 12'h000;
                // Wait for release of the entry press first
                if (gap_ms_q == 12'h000 && !any_pressed) begin
                    gap_ms_d = 12'h001;
                end else if (gap_ms_q != 12'h000 && one_pressed) begin
                    state_d     = ST_WAKE;
                    dir_up_d    = pressed.up;
                    restore_now = 1'b1;
                end
            end
            ST_WAKE: begin
                if (!any_pressed) begin
                    state_d = ST_IDLE;
                end else if (both_pressed) begin
                    state_d = ST_LOCKOUT;
                end else if (hold_ms_q >= 12'(WAKE_SCAN_MS - DB_MS)) begin
                    state_d   = ST_SCAN;
                    step_ms_d = 12'h000;
                    step_now  = 1'b1;
                end
            end
            default: state_d = ST_IDLE;
        endcase
    end

    // ----------------------------------------------------------------
    // Saturating position
    // ----------------------------------------------------------------
    always_comb begin
        pos_d   = pos_q;
        saved_d = saved_q;
        // Tracked while idle so a near-simultaneous second press can take the step back
        if (state_q == ST_IDLE) begin
            saved_d = pos_q;
        end
        if (save_now) begin
            saved_d = pos_q;
            pos_d   = POS_MIN;
        end else if (restore_now) begin
            pos_d = saved_q;
        end else if (step_now && dir_up_d && !at_top) begin
            pos_d = pos_q + 5'h01;
        end else if (step_now && !dir_up_d && !at_bot) begin
            pos_d = pos_q - 5'h01;
        end
    end

    always_ff @(posedge SYS_CLK_I or posedge SYS_RST_I) begin
        if (SYS_RST_I) begin
            state_q   <= ST_IDLE;
            hold_ms_q <= 12'h000;
            step_ms_q <= 12'h000;
            gap_ms_q  <= 12'h000;
            dir_up_q  <= 1'b0;
            pos_q     <= POS_RESET;
            saved_q   <= POS_RESET;
        end else begin
            state_q   <= state_d;
            hold_ms_q <= (state_d != state_q && state_q != ST_SCAN) ? 12'h000 : hold_ms_d;
            step_ms_q <= step_ms_d;
            gap_ms_q  <= (state_d != state_q) ? 12'h000 : gap_ms_d;
            dir_up_q  <= dir_up_d;
            pos_q     <= pos_d;
            saved_q   <= saved_d;
        end
    end

    // ----------------------------------------------------------------
    // Registered outputs
    // ----------------------------------------------------------------
    logic [TAP_N-1:0] tap_q;
    logic             shut_q;
    wire  [TAP_N-1:0] tap_d = {{(TAP_N-1){1'b0}}, 1'b1} << pos_d;

    always_ff @(posedge SYS_CLK_I or posedge SYS_RST_I) begin
        if (SYS_RST_I) begin
            tap_q  <= {{(TAP_N-1){1'b0}}, 1'b1};
            shut_q <= 1'b0;
        end else begin
            tap_q  <= tap_d;
            shut_q <= (state_d == ST_SHUTDOWN);
        end
    end

    assign TAP_SELECT_O          = tap_q;
    assign WIPER_POS_O           = pos_q;
    assign HIGH_END_DISCONNECT_O = shut_q;
    assign SHUTDOWN_O            = shut_q;

    // ----------------------------------------------------------------
    // Check helpers
    // ----------------------------------------------------------------
    // Counted apart from the sequencer so a broken step timer shows up
    logic [MS_W-1:0] since_q;
    logic [MS_W-1:0] both_ms_q;
    wire             pos_moves   = (pos_d != pos_q);
    wire             toward_free = dir_up_q ? !at_top : !at_bot;
    wire             since_sat   = (since_q == 12'hfff);
    wire             both_sat    = (both_ms_q == 12'hfff);
    wire [MS_W-1:0]  since_d     = pos_moves ? 12'h000 :
                                   (ms_tick && !since_sat) ? since_q + 12'h001 : since_q;
    wire [MS_W-1:0]  both_ms_d   = !both_pressed ? 12'h000 :
                                   (ms_tick && !both_sat) ? both_ms_q + 12'h001 : both_ms_q;

    always_ff @(posedge SYS_CLK_I or posedge SYS_RST_I) begin
        if (SYS_RST_I) begin
            since_q   <= 12'h000;
            both_ms_q <= 12'h000;
        end else begin
            since_q   <= since_d;
            both_ms_q <= both_ms_d;
        end
    end

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    AST_ONE_HOT: assert property (@(posedge SYS_CLK_I) disable iff (SYS_RST_I)
        $onehot(TAP_SELECT_O) && TAP_SELECT_O == (32'h1 << WIPER_POS_O)) else $error("tap select not one-hot");
    AST_NO_WRAP_UP: assert property (@(posedge SYS_CLK_I) disable iff (SYS_RST_I)
        (pos_q == POS_MAX && !restore_now) |=> pos_q != POS_MIN || $past(save_now)) else $error("wrapped at top");
    AST_NO_WRAP_DN: assert property (@(posedge SYS_CLK_I) disable iff (SYS_RST_I)
        (pos_q == POS_MIN && !restore_now) |=> pos_q != POS_MAX) else $error("wrapped at bottom");
    AST_SINGLE_STEP: assert property (@(posedge SYS_CLK_I) disable iff (SYS_RST_I)
        (step_now && !save_now && !restore_now) |=>
        (pos_q - $past(pos_q) == 5'h01 || $past(pos_q) - pos_q == 5'h01 || pos_q == $past(pos_q)))
        else $error("step larger than one tap");
    AST_SHUT_TAP0: assert property (@(posedge SYS_CLK_I) disable iff (SYS_RST_I)
        SHUTDOWN_O |-> WIPER_POS_O == POS_MIN && HIGH_END_DISCONNECT_O) else $error("shutdown wiper not at zero");
    AST_RESTORE: assert property (@(posedge SYS_CLK_I) disable iff (SYS_RST_I)
        restore_now |=> pos_q == $past(saved_q)) else $error("restore mismatch");
    AST_IDLE_RELEASE: assert property (@(posedge SYS_CLK_I) disable iff (SYS_RST_I)
        (state_q == ST_SCAN && !any_pressed) |=> state_q == ST_IDLE) else $error("scan did not stop");
    AST_LOCKOUT_HOLD: assert property (@(posedge SYS_CLK_I) disable iff (SYS_RST_I)
        (state_q == ST_LOCKOUT) |=> $stable(pos_q)) else $error("position moved in lockout");
    AST_NO_IDLE_STEP: assert property (@(posedge SYS_CLK_I) disable iff (SYS_RST_I)
        (state_q == ST_IDLE && !any_pressed) |=> $stable(pos_q)) else $error("step without press");
    AST_SHUT_AFTER_HOLD: assert property (@(posedge SYS_CLK_I) disable iff (SYS_RST_I)
        $rose(SHUTDOWN_O) |-> $past(both_ms_q) >= 12'(SHUTDOWN_MS - DB_MS)) else $error("shutdown before hold time");
    AST_PACE_FLOOR: assert property (@(posedge SYS_CLK_I) disable iff (SYS_RST_I)
        (state_q == ST_SCAN && pos_moves && !restore_now) |->
        since_q >= (fast_mode ? 12'(FAST_STEP_MS - 1) : 12'(SLOW_STEP_MS - 1))) else $error("scan step too early");
    AST_PACE_CEIL: assert property (@(posedge SYS_CLK_I) disable iff (SYS_RST_I)
        (state_q == ST_SCAN && one_pressed && toward_free) |-> since_q <= 12'(SLOW_STEP_MS)) else $error("scan stalled");
endmodule // push_button_wiper_control

// *** button_pair.sv ***
/*
 Model of the two push-button switches that sit on the far side.
 Assumes the bench commands each press by a level; an open switch reads high.
*/
`timescale 1ns/1ps
module button_pair (
    input  wire logic up_press_i,
    input  wire logic down_press_i,
    output logic      step_up_button_n_o,
    output logic      step_down_button_n_o
);
    // ------------------------------------------------------------
    // Switch to ground, pull-up level when open
    // ------------------------------------------------------------
    // Never left floating: the simulator would settle it arbitrarily
    assign step_up_button_n_o   = up_press_i ? 1'b0 : 1'b1;
    assign step_down_button_n_o = down_press_i ? 1'b0 : 1'b1;
endmodule // button_pair

// *** push_button_wiper_control_bench.sv ***
/*
 Self-checking bench for the push-button wiper control.
 Assumes a 5-cycle millisecond tick and a 2 ms debounce in simulation.
*/
`timescale 1ns/1ps
module push_button_wiper_control_bench;
    import wiper_pkg::*;
    // ------------------------------------------------------------
    // Signals
    // ------------------------------------------------------------
    localparam int unsigned MS  = 5;
    localparam int unsigned DBM = 2;
    logic             clk = 1'b0;
    logic             rst = 1'b1;
    logic             up_press = 1'b0;
    logic             down_press = 1'b0;
    wire logic        up_n;
    wire logic        down_n;
    logic [TAP_N-1:0] tap;
    logic [POS_W-1:0] pos;
    logic [POS_W-1:0] last_pos = '0;
    logic             high_cut;
    logic             sd;
    int               error_cnt = 0;
    int               n_checks = 0;
    int               cyc = 0;
    int               exp_pos = 0;
    int               ch_t[$];
    int               ch_v[$];

    always #5 clk = ~clk;

    button_pair u_button_pair (
        .up_press_i          (up_press),
        .down_press_i        (down_press),
        .step_up_button_n_o  (up_n),
        .step_down_button_n_o(down_n)
    );

    push_button_wiper_control #(.TICK_DIV(MS), .DB_MS(DBM)) u_push_button_wiper_control (
        .SYS_CLK_I            (clk),
        .SYS_RST_I            (rst),
        .STEP_UP_BUTTON_N_I   (up_n),
        .STEP_DOWN_BUTTON_N_I (down_n),
        .TAP_SELECT_O         (tap),
        .WIPER_POS_O          (pos),
        .HIGH_END_DISCONNECT_O(high_cut),
        .SHUTDOWN_O           (sd)
    );

    // ------------------------------------------------------------
    // Step log: time and value of every position change
    // ------------------------------------------------------------
    always @(posedge clk) begin
        cyc <= cyc + 1;
        last_pos <= pos;
        if (pos !== last_pos) begin
            ch_t.push_back(cyc);
            ch_v.push_back(int'(pos));
        end
    end

    // ------------------------------------------------------------
    // Compare and stimulus tasks
    // ------------------------------------------------------------
    task automatic fail(input string m);
        error_cnt++;
        $display("wrong value at %0t: %s", $time, m);
    endtask

    task automatic chk_pos(input int e);
        n_checks++;
        if (pos !== e[POS_W-1:0] || tap !== (32'h1 << e)) fail("wiper position");
    endtask

    task automatic chk_flag(input logic g, input logic e, input string m);
        n_checks++;
        if (g !== e) fail(m);
    endtask

    task automatic chk_range(input int v, input int lo, input int hi, input string m);
        n_checks++;
        if (v < lo || v > hi) fail(m);
    endtask

    task automatic wait_ms(input int n);
        repeat (n * MS) @(posedge clk);
    endtask

    task automatic prs(input logic u, input logic d);
        @(posedge clk);
        up_press <= u;
        down_press <= d;
    endtask

    // Release leaves a 30 ms gap so the next press starts from idle
    task automatic rel();
        prs(1'b0, 1'b0);
        wait_ms(30);
    endtask

    task automatic hold(input logic u, input logic d, input int n);
        prs(u, d);
        wait_ms(n);
        rel();
    endtask

    task automatic tally_and_finish();
        $display("checks %0d errors %0d", n_checks, error_cnt);
        if (error_cnt == 0 && n_checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    // ------------------------------------------------------------
    // Watchdog, sized a little above the planned sequence
    // ------------------------------------------------------------
    initial begin
        repeat (60000) @(posedge clk);
        error_cnt++;
        tally_and_finish();
    end

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        void'($urandom(32'h3b3b));
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        wait_ms(5);
        chk_pos(0);
        chk_flag(sd, 1'b0, "shutdown after reset");
        chk_flag(up_n, 1'b1, "idle button level");
        hold(1'b1, 1'b0, 1);
        chk_pos(0);
        hold(1'b0, 1'b1, 50);
        chk_pos(0);
        hold(1'b1, 1'b0, 100);
        chk_pos(1);
        hold(1'b1, 1'b0, 100);
        chk_pos(2);
        hold(1'b0, 1'b1, 100);
        chk_pos(1);
        // Long hold: slow then fast scan up to the top end
        ch_t.delete();
        ch_v.delete();
        hold(1'b1, 1'b0, 2600);
        wait_ms(50);
        chk_pos(31);
        chk_range(ch_v.size(), 30, 30, "step count");
        for (int k = 1; k < ch_t.size(); k++) begin
            chk_range(ch_v[k] - ch_v[k-1], 1, 1, "step size");
            if (ch_t[k] - ch_t[0] <= 1000 * MS) begin
                chk_range(ch_t[k] - ch_t[k-1], 100 * MS, 375 * MS, "slow interval");
            end else if (ch_t[k-1] - ch_t[0] >= 1000 * MS) begin
                chk_range(ch_t[k] - ch_t[k-1], 25 * MS, 75 * MS, "fast interval");
            end
        end
        // Both buttons a cycle apart, inside the window: shutdown after two seconds
        prs(1'b1, 1'b0);
        prs(1'b1, 1'b1);
        wait_ms(1800);
        chk_flag(sd, 1'b0, "early shutdown");
        chk_pos(31);
        wait_ms(300);
        chk_flag(sd, 1'b1, "shutdown entry");
        chk_flag(high_cut, 1'b1, "high end cut");
        chk_pos(0);
        rel();
        wait_ms(20);
        chk_flag(sd, 1'b1, "shutdown held");
        // Exit press restores only, a longer hold then scans
        prs(1'b0, 1'b1);
        wait_ms(100);
        chk_pos(31);
        chk_flag(sd, 1'b0, "shutdown exit");
        chk_flag(high_cut, 1'b0, "high end restored");
        wait_ms(300);
        rel();
        wait_ms(200);
        chk_pos(30);
        // Second button pressed late: everything dropped until release
        prs(1'b0, 1'b1);
        wait_ms(100);
        prs(1'b1, 1'b1);
        wait_ms(2200);
        chk_pos(29);
        chk_flag(sd, 1'b0, "shutdown from lockout");
        rel();
        hold(1'b1, 1'b0, 100);
        chk_pos(30);
        // Random short presses against the saturating reference
        exp_pos = 30;
        for (int i = 0; i < 8; i++) begin
            automatic logic dir = 1'($urandom_range(1, 0));
            automatic int n = int'($urandom_range(200, 20));
            hold(dir, !dir, n);
            exp_pos = dir ? ((exp_pos < 31) ? exp_pos + 1 : 31) : ((exp_pos > 0) ? exp_pos - 1 : 0);
            chk_pos(exp_pos);
        end
        tally_and_finish();
    end
endmodule // push_button_wiper_control_bench
